/* File: pkg/dpi_map.vh */
`ifndef DPI_MAP_VH
`define DPI_MAP_VH

// packed instruction descriptor carried down the pipe
`define DPI_W          22
`define DPI_F_VALID    0
`define DPI_F_LOAD     1
`define DPI_F_STORE    2
`define DPI_F_DSPSIDE  3
`define DPI_F_UADDR    4
`define DPI_F_DSPOP    5
`define DPI_F_MUL      6
`define DPI_F_MLONG    7
`define DPI_F_RACC     8
`define DPI_F_MEM      9
`define DPI_F_DST      10
`define DPI_F_AREG     14
`define DPI_F_SRC      18
`define DPI_RIDX_W     4

// reset value of every stage register: an empty slot
`define DPI_SLOT_EMPTY 22'h00_0000

// memory-access phase of a two-access multiply instruction
`define DPI_PHASE_FIRST  1'h0
`define DPI_PHASE_SECOND 1'h1

// multiplier access length after the last memory access, in cycles
`define DPI_MM_LONG_CYC  3'h4
`define DPI_MM_SHORT_CYC 3'h2
`define DPI_MM_IDLE      3'h0
`define DPI_MM_STEP      3'h1

`endif

/* File: core/dpi_mult_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "dpi_map.vh"

module dpi_mult_timer (
    // clock and reset
    input  wire       i_clock,
    input  wire       i_sys_rst,
    // start of multiplier access
    input  wire       i_start,
    input  wire       i_long,
    // busy state
    output wire       o_busy,
    output wire [2:0] o_count
);

    reg  [2:0] count_q;
    reg  [2:0] count_d;

    // load the access length on start, otherwise count down to idle
    always @* begin
        count_d = count_q;
        if (i_start) begin
            count_d = i_long ? `DPI_MM_LONG_CYC : `DPI_MM_SHORT_CYC;
        end else if (count_q != `DPI_MM_IDLE) begin
            count_d = count_q - `DPI_MM_STEP;
        end
    end

    // counting ignores slot boundaries: it never waits on the pipe
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            count_q <= `DPI_MM_IDLE;
        end else begin
            count_q <= count_d;
        end
    end

    assign o_busy  = (count_q != `DPI_MM_IDLE);
    assign o_count = count_q;

endmodule // dpi_mult_timer

`default_nettype wire

/* File: core/dpi_pipe_interlock.v */
`timescale 1ns/1ps
`default_nettype none
`include "dpi_map.vh"

module dpi_pipe_interlock (
    // clock and reset
    input  wire                    i_clock,
    input  wire                    i_sys_rst,
    // instruction entering decode
    input  wire                    i_ins_valid,
    input  wire                    i_ins_load,
    input  wire                    i_ins_store,
    input  wire                    i_ins_dsp_side,
    input  wire                    i_ins_uses_addr,
    input  wire                    i_ins_dsp_op,
    input  wire                    i_ins_mul,
    input  wire                    i_ins_mul_long,
    input  wire                    i_ins_reads_acc,
    input  wire                    i_ins_mem,
    input  wire [3:0]              i_ins_dst,
    input  wire [3:0]              i_ins_addr_reg,
    input  wire [3:0]              i_ins_src,
    output wire                    o_ins_ready,
    // internal data bus
    input  wire                    i_mem_ready,
    input  wire [31:0]             i_bus_rdata,
    input  wire [31:0]             i_store_operand,
    output wire [31:0]             o_bus_wdata,
    output wire                    o_fwd_active,
    // memory access stage view
    output wire                    o_ma_valid,
    output wire                    o_ma_load,
    output wire                    o_ma_store,
    output wire                    o_ma_done,
    output wire                    o_ma_phase,
    output wire [3:0]              o_ma_addr_reg,
    // writeback stage: register file and dsp unit
    output wire                    o_rf_we,
    output wire                    o_rf_dsp_side,
    output wire [3:0]              o_rf_waddr,
    output wire [31:0]             o_rf_wdata,
    output wire                    o_dsp_exec,
    output wire [3:0]              o_dsp_dst,
    // multiplier unit
    output wire                    o_mult_start,
    output wire                    o_mult_long,
    output wire                    o_mult_busy,
    // stage occupancy and stall causes
    output wire                    o_dec_valid,
    output wire                    o_ex_valid,
    output wire                    o_wb_valid,
    output wire                    o_stall_addr,
    output wire                    o_stall_dsp_store,
    output wire                    o_stall_acc,
    output wire                    o_stall_mul_ma
);

    // register index field of a descriptor
    function [3:0] fld4;
        input [`DPI_W-1:0] desc;
        input integer      lsb;
        begin
            fld4 = desc[lsb +: `DPI_RIDX_W];
        end
    endfunction

    // true when a writer's index field names a reader's register
    function same_reg;
        input [`DPI_W-1:0] wr_desc;
        input integer      wr_lsb;
        input [`DPI_W-1:0] rd_desc;
        input integer      rd_lsb;
        begin
            same_reg = (fld4(wr_desc, wr_lsb) == fld4(rd_desc, rd_lsb));
        end
    endfunction

    // stage registers
    reg  [`DPI_W-1:0] dec_q;
    reg  [`DPI_W-1:0] dec_d;
    reg  [`DPI_W-1:0] ex_q;
    reg  [`DPI_W-1:0] ex_d;
    reg  [`DPI_W-1:0] ma_q;
    reg  [`DPI_W-1:0] ma_d;
    reg  [`DPI_W-1:0] wb_q;
    reg  [`DPI_W-1:0] wb_d;
    reg               phase_q;
    reg               phase_d;

    wire [`DPI_W-1:0] ins_desc;
    wire              mult_busy;
    wire [2:0]        mult_count;
    wire              stall_addr;
    wire              stall_dsp;
    wire              stall_acc;
    wire              mm_ending;
    wire              ma_mul_wait;
    wire              ma_mem_wait;
    wire              ma_done;
    wire              ma_free;
    wire              ex_move;
    wire              ex_free;
    wire              dec_move;
    wire              dec_free;
    wire              mult_start;
    wire              fwd;

    // pack the incoming instruction, flag bits lowest;
    // every stage register reuses this one layout
    assign ins_desc = {i_ins_src, i_ins_addr_reg, i_ins_dst, i_ins_mem,
                       i_ins_reads_acc, i_ins_mul_long, i_ins_mul,
                       i_ins_dsp_op, i_ins_uses_addr, i_ins_dsp_side,
                       i_ins_store, i_ins_load, i_ins_valid};

    // pointer hazard: a core load in operate feeds the next address;
    // dsp-side loads write dsp registers, never pointers, so they pass
    assign stall_addr = dec_q[`DPI_F_VALID] && dec_q[`DPI_F_UADDR]
                     && ex_q[`DPI_F_VALID] && ex_q[`DPI_F_LOAD]
                     && !ex_q[`DPI_F_DSPSIDE]
                     && same_reg(ex_q, `DPI_F_DST, dec_q, `DPI_F_AREG);

    // dsp result not ready before the writeback stage ends;
    // core results come from operate, so no term for them;
    // only a dsp-side store can carry a dsp register
    assign stall_dsp = ex_q[`DPI_F_VALID] && ex_q[`DPI_F_STORE]
                    && ex_q[`DPI_F_DSPSIDE]
                    && ma_q[`DPI_F_VALID] && ma_q[`DPI_F_DSPOP]
                    && same_reg(ma_q, `DPI_F_DST, ex_q, `DPI_F_SRC);

    // accumulator readers wait until multiplier access is over; the
    // reader may leave operate in the last busy cycle, as its own
    // access then starts just after the multiplier has finished
    assign mm_ending = (mult_count <= `DPI_MM_STEP);
    assign stall_acc = ex_q[`DPI_F_VALID] && ex_q[`DPI_F_RACC]
                    && (!mm_ending || (ma_q[`DPI_F_VALID] && ma_q[`DPI_F_MUL]));

    // multiply with memory operands takes two accesses; its last one
    // is stretched while the previous multiplier access runs
    assign ma_mul_wait = ma_q[`DPI_F_VALID] && ma_q[`DPI_F_MUL]
                      && ((ma_q[`DPI_F_MEM] && (phase_q == `DPI_PHASE_FIRST))
                          || mult_busy);

    // bus wait states stretch any memory access but the first of a two-access multiply; the held access
    // keeps its slot, so every younger stage holds as well, up to the first empty slot ahead of it
    assign ma_mem_wait = ma_q[`DPI_F_VALID] && ma_q[`DPI_F_MEM] && !i_mem_ready;

    // an access is done once no multiplier or bus wait holds it
    assign ma_done = ma_q[`DPI_F_VALID] && !ma_mul_wait && !ma_mem_wait;
    assign ma_free = !ma_q[`DPI_F_VALID] || ma_done;

    // a blocked stage blocks everything younger than it, up to the first empty slot
    assign ex_move  = ex_q[`DPI_F_VALID] && ma_free && !stall_dsp && !stall_acc;
    assign ex_free  = !ex_q[`DPI_F_VALID] || ex_move;
    assign dec_move = dec_q[`DPI_F_VALID] && ex_free && !stall_addr;
    assign dec_free = !dec_q[`DPI_F_VALID] || dec_move;

    // multiplier access starts as the last memory access ends;
    // a start never meets a busy timer, the access waits first
    assign mult_start = ma_done && ma_q[`DPI_F_MUL];

    // writeback takes whatever finishes its access, else a bubble
    always @* begin
        wb_d = ma_done ? ma_q : `DPI_SLOT_EMPTY;
    end

    // access stage refills from operate, or empties when done
    always @* begin
        if (ex_move) begin
            ma_d = ex_q;
        end else if (ma_done) begin
            ma_d = `DPI_SLOT_EMPTY;
        end else begin
            ma_d = ma_q;
        end
    end

    // operate keeps a stalled instruction in place; a bubble
    // enters when decode is empty or held back by a hazard
    always @* begin
        if (dec_move) begin
            ex_d = dec_q;
        end else if (ex_move) begin
            ex_d = `DPI_SLOT_EMPTY;
        end else begin
            ex_d = ex_q;
        end
    end

    // decode takes a new offer only when its slot frees up
    always @* begin
        if (i_ins_valid && dec_free) begin
            dec_d = ins_desc;
        end else if (dec_move) begin
            dec_d = `DPI_SLOT_EMPTY;
        end else begin
            dec_d = dec_q;
        end
    end

    // access phase: first access always lasts one cycle;
    // a bus wait there is absorbed by the second access
    always @* begin
        phase_d = phase_q;
        if (ma_free) begin
            phase_d = `DPI_PHASE_FIRST;
        end else if (ma_q[`DPI_F_MUL] && ma_q[`DPI_F_MEM]
                     && (phase_q == `DPI_PHASE_FIRST)) begin
            phase_d = `DPI_PHASE_SECOND;
        end
    end

    // pipeline registers; reset empties every slot so no stale
    // descriptor can raise a hazard after release
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            dec_q   <= `DPI_SLOT_EMPTY;
            ex_q    <= `DPI_SLOT_EMPTY;
            ma_q    <= `DPI_SLOT_EMPTY;
            wb_q    <= `DPI_SLOT_EMPTY;
            phase_q <= `DPI_PHASE_FIRST;
        end else begin
            dec_q   <= dec_d;
            ex_q    <= ex_d;
            ma_q    <= ma_d;
            wb_q    <= wb_d;
            phase_q <= phase_d;
        end
    end

    // multiplier access timer; it runs free of slot boundaries,
    // so only its count tells when the last busy cycle has come
    dpi_mult_timer u_mult_timer (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_start   (mult_start),
        .i_long    (ma_q[`DPI_F_MLONG]),
        .o_busy    (mult_busy),
        .o_count   (mult_count)
    );

    // load in writeback feeding a store in access: same register file
    // side on both, so core and dsp transfers share one forward path
    assign fwd = wb_q[`DPI_F_VALID] && wb_q[`DPI_F_LOAD]
              && ma_q[`DPI_F_VALID] && ma_q[`DPI_F_STORE]
              && (wb_q[`DPI_F_DSPSIDE] == ma_q[`DPI_F_DSPSIDE])
              && same_reg(wb_q, `DPI_F_DST, ma_q, `DPI_F_SRC);

    // bus data re-driven in the cycle it is written; a flop here
    // would cost the very stall this path exists to avoid
    assign o_bus_wdata  = fwd ? i_bus_rdata : i_store_operand;
    assign o_fwd_active = fwd;

    // writeback: register write and dsp operation; write data
    // comes straight off the bus, unregistered, so that it shares
    // the cycle with a forwarded store
    assign o_rf_we       = wb_q[`DPI_F_VALID] && wb_q[`DPI_F_LOAD];
    assign o_rf_dsp_side = wb_q[`DPI_F_DSPSIDE];
    assign o_rf_waddr    = fld4(wb_q, `DPI_F_DST);
    assign o_rf_wdata    = i_bus_rdata;
    assign o_dsp_exec    = wb_q[`DPI_F_VALID] && wb_q[`DPI_F_DSPOP];
    assign o_dsp_dst     = fld4(wb_q, `DPI_F_DST);

    // memory access stage
    assign o_ma_valid    = ma_q[`DPI_F_VALID];
    assign o_ma_load     = ma_q[`DPI_F_VALID] && ma_q[`DPI_F_LOAD];
    assign o_ma_store    = ma_q[`DPI_F_VALID] && ma_q[`DPI_F_STORE];
    assign o_ma_done     = ma_done;
    assign o_ma_phase    = phase_q;
    assign o_ma_addr_reg = fld4(ma_q, `DPI_F_AREG);

    // multiplier and occupancy; decode after a double-length
    // multiply is not held an extra slot, so a younger
    // instruction may reach operate one cycle earlier there
    assign o_mult_start  = mult_start;
    assign o_mult_long   = ma_q[`DPI_F_MLONG];
    assign o_mult_busy   = mult_busy;
    assign o_ins_ready   = dec_free;
    assign o_dec_valid   = dec_q[`DPI_F_VALID];
    assign o_ex_valid    = ex_q[`DPI_F_VALID];
    assign o_wb_valid    = wb_q[`DPI_F_VALID];

    // stall causes, level, for observation;
    // several may be high in one cycle, none is a pulse
    assign o_stall_addr      = stall_addr;
    assign o_stall_dsp_store = stall_dsp;
    assign o_stall_acc       = stall_acc;
    assign o_stall_mul_ma    = ma_mul_wait;

endmodule // dpi_pipe_interlock

`default_nettype wire

/* File: tb/dpi_pipe_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dpi_pipe_checker (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    // watched ports
    input wire logic        i_mem_ready,
    input wire logic [31:0] i_bus_rdata,
    input wire logic [31:0] o_bus_wdata,
    input wire logic        o_fwd_active,
    input wire logic        o_ins_ready,
    input wire logic        o_ma_valid,
    input wire logic        o_ma_done,
    input wire logic        o_ma_phase,
    input wire logic        o_rf_we,
    input wire logic        o_dsp_exec,
    input wire logic        o_mult_start,
    input wire logic        o_mult_long,
    input wire logic        o_mult_busy,
    input wire logic        o_dec_valid,
    input wire logic        o_ex_valid,
    input wire logic        o_stall_addr,
    input wire logic        o_stall_dsp_store,
    input wire logic        o_stall_acc
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    // forwarding and bubbles tied to their causes
    fwd_data_a: assert property (
        o_fwd_active |-> o_rf_we && o_bus_wdata == i_bus_rdata)
        else $error("forward data wrong");
    addr_stall_a: assert property (
        o_stall_addr ##1 !o_stall_addr |-> o_dec_valid && !o_ex_valid)
        else $error("pointer bubble wrong");
    dsp_stall_a: assert property (
        o_stall_dsp_store && o_ma_done |=> o_dsp_exec && !o_ma_valid)
        else $error("dsp store bubble wrong");
    hold_young_a: assert property (
        o_stall_addr || (o_dec_valid && (o_stall_acc || o_stall_dsp_store)) |-> !o_ins_ready)
        else $error("decode taken in stall");
    // a ready, idle-multiplier access that is not done must be a first mac access
    mac_phase_a: assert property (
        o_ma_valid && !o_ma_phase && !o_ma_done && i_mem_ready && !o_mult_busy |=> o_ma_phase)
        else $error("second access missing");
    // multiplier busy length; a start never overlaps it
    mul_short_a: assert property (
        o_mult_start && !o_mult_long |=> o_mult_busy [*2] ##1 !o_mult_busy)
        else $error("short busy length");
    mul_long_a: assert property (
        o_mult_start && o_mult_long |=> o_mult_busy [*4] ##1 !o_mult_busy)
        else $error("long busy length");
    mul_wait_a: assert property (
        o_mult_busy |-> !o_mult_start)
        else $error("start while busy");
endmodule // dpi_pipe_checker

bind dpi_pipe_interlock dpi_pipe_checker dpi_pipe_checker_inst (
    .i_clock           (i_clock),
    .i_sys_rst         (i_sys_rst),
    .i_mem_ready       (i_mem_ready),
    .i_bus_rdata       (i_bus_rdata),
    .o_bus_wdata       (o_bus_wdata),
    .o_fwd_active      (o_fwd_active),
    .o_ins_ready       (o_ins_ready),
    .o_ma_valid        (o_ma_valid),
    .o_ma_done         (o_ma_done),
    .o_ma_phase        (o_ma_phase),
    .o_rf_we           (o_rf_we),
    .o_dsp_exec        (o_dsp_exec),
    .o_mult_start      (o_mult_start),
    .o_mult_long       (o_mult_long),
    .o_mult_busy       (o_mult_busy),
    .o_dec_valid       (o_dec_valid),
    .o_ex_valid        (o_ex_valid),
    .o_stall_addr      (o_stall_addr),
    .o_stall_dsp_store (o_stall_dsp_store),
    .o_stall_acc       (o_stall_acc)
);
`default_nettype wire

/* File: tb/dpi_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpi_bus_model (
    // clock and mode
    input  wire logic       i_clock,
    input  wire logic       i_slow,
    // access from the pipeline
    input  wire logic       i_ma_valid,
    input  wire logic       i_ma_load,
    input  wire logic       i_ma_done,
    input  wire logic [3:0] i_ma_addr_reg,
    // bus answer
    output logic            o_ready,
    output logic [31:0]     o_rdata
);
    logic        waited_q = 1'b0;
    logic [31:0] data_q   = 32'h0000_0000;
    // slow mode: one wait state per access, so held stages get exercised
    assign o_ready = !(i_slow && i_ma_valid && !waited_q);
    // load data tagged by pointer, flips in every cycle in which no load completes
    always @(posedge i_clock) begin
        waited_q <= i_ma_valid && !i_ma_done;
        if (i_ma_done && i_ma_load)
            data_q <= {28'ha5a_5c3c, i_ma_addr_reg};
        else
            data_q <= ~data_q;
    end
    assign o_rdata = data_q;
endmodule // dpi_bus_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    // flags fl: {mem,acc,long,mul,op,ptr,dsp,st,ld}
    logic        i_clock         = 1'b0;
    logic        i_sys_rst       = 1'b1;
    logic        i_ins_valid     = 1'b0;
    logic        slow            = 1'b0;
    logic [8:0]  fl              = 9'h000;
    logic [3:0]  i_ins_dst       = 4'h0;
    logic [3:0]  i_ins_addr_reg  = 4'h0;
    logic [3:0]  i_ins_src       = 4'h0;
    logic [31:0] i_store_operand = 32'h1357_9bdf;
    int          error_cnt       = 0;
    int          n_checks        = 0;
    wire         i_mem_ready, o_ins_ready, o_fwd_active, o_ma_valid, o_ma_load, o_ma_store;
    wire         o_ma_done, o_ma_phase, o_rf_we, o_rf_dsp_side, o_dsp_exec, o_mult_start;
    wire         o_mult_long, o_mult_busy, o_dec_valid, o_ex_valid, o_wb_valid, o_stall_addr;
    wire         o_stall_dsp_store, o_stall_acc, o_stall_mul_ma;
    wire [3:0]   o_ma_addr_reg, o_rf_waddr, o_dsp_dst;
    wire [31:0]  i_bus_rdata, o_bus_wdata, o_rf_wdata;

    always #2.5 i_clock = ~i_clock;

    dpi_pipe_interlock dpi_pipe_interlock_inst (
        .i_clock          (i_clock),
        .i_sys_rst        (i_sys_rst),
        .i_ins_valid      (i_ins_valid),
        .i_ins_load       (fl[0]),
        .i_ins_store      (fl[1]),
        .i_ins_dsp_side   (fl[2]),
        .i_ins_uses_addr  (fl[3]),
        .i_ins_dsp_op     (fl[4]),
        .i_ins_mul        (fl[5]),
        .i_ins_mul_long   (fl[6]),
        .i_ins_reads_acc  (fl[7]),
        .i_ins_mem        (fl[8]),
        .i_ins_dst        (i_ins_dst),
        .i_ins_addr_reg   (i_ins_addr_reg),
        .i_ins_src        (i_ins_src),
        .o_ins_ready      (o_ins_ready),
        .i_mem_ready      (i_mem_ready),
        .i_bus_rdata      (i_bus_rdata),
        .i_store_operand  (i_store_operand),
        .o_bus_wdata      (o_bus_wdata),
        .o_fwd_active     (o_fwd_active),
        .o_ma_valid       (o_ma_valid),
        .o_ma_load        (o_ma_load),
        .o_ma_store       (o_ma_store),
        .o_ma_done        (o_ma_done),
        .o_ma_phase       (o_ma_phase),
        .o_ma_addr_reg    (o_ma_addr_reg),
        .o_rf_we          (o_rf_we),
        .o_rf_dsp_side    (o_rf_dsp_side),
        .o_rf_waddr       (o_rf_waddr),
        .o_rf_wdata       (o_rf_wdata),
        .o_dsp_exec       (o_dsp_exec),
        .o_dsp_dst        (o_dsp_dst),
        .o_mult_start     (o_mult_start),
        .o_mult_long      (o_mult_long),
        .o_mult_busy      (o_mult_busy),
        .o_dec_valid      (o_dec_valid),
        .o_ex_valid       (o_ex_valid),
        .o_wb_valid       (o_wb_valid),
        .o_stall_addr     (o_stall_addr),
        .o_stall_dsp_store(o_stall_dsp_store),
        .o_stall_acc      (o_stall_acc),
        .o_stall_mul_ma   (o_stall_mul_ma)
    );
    dpi_bus_model dpi_bus_model_inst (
        .i_clock      (i_clock),
        .i_slow       (slow),
        .i_ma_valid   (o_ma_valid),
        .i_ma_load    (o_ma_load),
        .i_ma_done    (o_ma_done),
        .i_ma_addr_reg(o_ma_addr_reg),
        .o_ready      (i_mem_ready),
        .o_rdata      (i_bus_rdata)
    );

    // inputs move 1 ns after the edge so the edge never races them
    task automatic step();
        @(posedge i_clock);
        #1;
    endtask
    task automatic idle(input int c);
        i_ins_valid = 1'b0;
        repeat (c) step();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // a wait that runs out counts as a mismatch and ends the run
    task automatic guard(input int n);
        if (n >= 20) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    // valid stays up so back-to-back offers never toggle it twice
    task automatic issue(input logic [8:0] f, input logic [3:0] d, a, s);
        int n = 0;
        {fl, i_ins_dst, i_ins_addr_reg, i_ins_src} = {f, d, a, s};
        i_ins_valid = 1'b1;
        while (o_ins_ready !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        guard(n);
        step();
    endtask

    // loaded register used as pointer, slow bus holding the load
    task automatic scn_pointer();
        slow = 1'b1;
        issue(9'h101, 4'h3, 4'h1, 4'h0);
        issue(9'h109, 4'h7, 4'h3, 4'h0);
        check({o_stall_addr, o_ins_ready}, 2'h2);
        idle(1);
        check({o_ma_load, o_ma_done, o_ex_valid, o_dec_valid}, 4'h9);
        idle(2);
        check({o_ma_valid, o_ma_addr_reg}, 5'h13);
        slow = 1'b0;
        idle(8);
    endtask
    // dsp result stored next gets one bubble, core result none
    task automatic scn_store();
        issue(9'h010, 4'h4, 4'h0, 4'h0);
        issue(9'h106, 4'h0, 4'h1, 4'h4);
        idle(1);
        check(o_stall_dsp_store, 1'b1);
        idle(1);
        check({o_dsp_exec, o_ma_valid}, 2'h2);
        check({o_wb_valid, o_dsp_dst}, 5'h14);
        issue(9'h000, 4'h4, 4'h0, 4'h0);
        check({o_ma_store, o_fwd_active}, 2'h2);
        check(o_bus_wdata, i_store_operand);
        issue(9'h102, 4'h0, 4'h1, 4'h4);
        idle(1);
        check(o_stall_dsp_store, 1'b0);
        idle(1);
        check({o_ma_store, o_ma_done}, 2'h3);
        idle(8);
    endtask
    // load then store of one register, core side then dsp side
    task automatic scn_forward();
        for (int side = 0; side < 2; side++) begin
            issue(9'h101 | {6'h00, side[0], 2'h0}, 4'h6, 4'h9, 4'h0);
            issue(9'h102 | {6'h00, side[0], 2'h0}, 4'h0, 4'h2, 4'h6);
            idle(2);
            check({o_fwd_active, o_ma_done, o_rf_we}, 3'h7);
            check(o_bus_wdata, 32'ha5a5_c3c9);
            check({o_rf_dsp_side, o_rf_waddr}, {side[0], 4'h6});
            check(o_rf_wdata, 32'ha5a5_c3c9);
            idle(6);
        end
    endtask
    // multiply then accumulator read or another multiply
    task automatic scn_mul(input logic [8:0] mac, input logic [8:0] nxt, input int gap);
        int n = 0;
        issue(mac, 4'h0, 4'h1, 4'h2);
        issue(nxt, 4'h3, 4'h4, 4'h5);
        idle(1);
        check({o_stall_acc, o_ma_phase, o_stall_mul_ma}, {nxt[7], 2'b01});
        idle(1);
        check({o_ma_phase, o_mult_start, o_stall_mul_ma, o_mult_long}, {3'h6, mac[6]});
        do begin
            idle(1);
            n++;
        end while ((nxt[5] ? o_mult_start : o_ma_valid) !== 1'b1 && n < 20);
        guard(n);
        check(n, gap);
        idle(8);
    endtask

    // reset, scenarios, verdict
    initial begin
        repeat (6) @(posedge i_clock);
        #1;
        i_sys_rst = 1'b0;
        scn_pointer();
        scn_store();
        scn_forward();
        scn_mul(9'h120, 9'h080, 3);
        scn_mul(9'h160, 9'h180, 5);
        scn_mul(9'h160, 9'h160, 5);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
